// file: design/serp_pkg.sv
// Shared constants for the sensor event pin router.
// Assumes a single 50 MHz clock domain.
package serp_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS      = 20;
    localparam int SAMPLE_READY_FLAG_PULSE_NS      = 90_000;
    localparam int SAMPLE_READY_FLAG_PULSE_CYCLES  = (SAMPLE_READY_FLAG_PULSE_NS / CLK_PERIOD_NS < 1) ? 1
                                        : SAMPLE_READY_FLAG_PULSE_NS / CLK_PERIOD_NS;
    localparam int EMB_LEAD_NS        = 150_000;
    localparam int EMB_LEAD_CYCLES    = (EMB_LEAD_NS / CLK_PERIOD_NS < 1) ? 1
                                        : EMB_LEAD_NS / CLK_PERIOD_NS;
    localparam int TS_ALERT_MARGIN_NS = 2_500_000;

    // ----------------------------------------
    // Routing registers
    // ----------------------------------------
    localparam logic [7:0] ROUTE_RESET   = 8'h00;
    localparam logic [7:0] MISC_WR_MASK  = 8'hF8;
    localparam logic [7:0] EVENT_WR_MASK = 8'hBF;
    localparam int MISC_BOOT   = 7;
    localparam int MISC_QFULL  = 6;
    localparam int MISC_QLEVEL = 5;
    localparam int MISC_QOVR   = 4;
    localparam int MISC_SAMPLE_READY_FLAG   = 3;
    localparam int EV_SLEEP    = 7;
    localparam int EV_WAKE     = 5;
    localparam int EV_FF       = 4;
    localparam int EV_TAP      = 3;
    localparam int EV_ORIENT   = 2;
    localparam int EV_TS       = 1;
    localparam int EV_EMB      = 0;

    // ----------------------------------------
    // Basic event index, also combined source bit
    // ----------------------------------------
    localparam int NUM_BASIC   = 5;
    localparam int SRC_ORIENT  = 0;
    localparam int SRC_FF      = 1;
    localparam int SRC_WAKE    = 2;
    localparam int SRC_TAP     = 3;
    localparam int SRC_SLEEP   = 4;

    // ----------------------------------------
    // Status register bits
    // ----------------------------------------
    localparam int STAT_SAMPLE_READY_FLAG   = 0;
    localparam int STAT_GLOBAL = 5;

    typedef enum logic [1:0] {
        SERP_IDLE    = 2'b00,
        SERP_HELD    = 2'b01,
        SERP_RELEASE = 2'b10
    } serp_latch_t;

endpackage

// file: design/serp_pulse_timer.sv
// One-shot cycle timer: busy for CYCLES clocks after start, then a done pulse.
// Assumes start is a single-cycle pulse on ref_clk.
`timescale 1ns/1ps
module serp_pulse_timer #(
    parameter int CYCLES = 4500
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);

    generate
        if (CYCLES < 1) begin : g_bad
            $error("serp_pulse_timer: CYCLES must be at least 1");
        end
    endgenerate

    logic [W-1:0] count;

    // A fresh start restarts the window rather than queueing a second one
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy  <= 1'b1;
                count <= '0;
            end else if (busy) begin
                if (count == W'(CYCLES - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule

// file: design/serp_router.sv
// Interrupt routing and latching for the motion/biopotential sensor pin.
// Assumes detector levels, queue flags and read strobes are synchronous
// to ref_clk; read strobes are one-cycle pulses from the serial interface.
`timescale 1ns/1ps

module serp_router import serp_pkg::*; #(
    parameter int SAMPLE_READY_FLAG_PULSE_LEN = SAMPLE_READY_FLAG_PULSE_CYCLES,
    parameter int EMB_LEAD_LEN   = EMB_LEAD_CYCLES,
    parameter int TS_WIDTH       = 32,
    parameter int TS_LSB_NS      = 25_000
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                wr_misc,
    input  wire logic                wr_event,
    input  wire logic [7:0]          wr_data,
    output logic      [7:0]          route_misc_select,
    output logic      [7:0]          route_event_select,
    input  wire logic                pin_polarity_low,
    input  wire logic                drain_select,
    input  wire logic                request_pin_enable,
    input  wire logic                latch_basic_events,
    input  wire logic                latch_embedded_events,
    input  wire logic                keep_flags_on_combined_read,
    input  wire logic                ready_pulse_mode,
    input  wire logic                basic_events_on,
    input  wire logic                embedded_features_on,
    input  wire logic [7:0]          embedded_ack_mask,
    input  wire logic                active_mode,
    input  wire logic                bio_only,
    input  wire logic                odr_tick,
    input  wire logic [NUM_BASIC-1:0] basic_event,
    input  wire logic [7:0]          emb_request,
    input  wire logic [TS_WIDTH-1:0] ts_count,
    input  wire logic                boot_status,
    input  wire logic                queue_full,
    input  wire logic                queue_level,
    input  wire logic                queue_overrun,
    input  wire logic                rd_combined,
    input  wire logic [NUM_BASIC-1:0] rd_specific,
    input  wire logic                rd_emb_status,
    input  wire logic                rd_axis_high,
    output logic      [7:0]          combined_event_source,
    output logic      [7:0]          status_reg,
    output logic      [7:0]          emb_status,
    output logic                     int_out,
    output logic                     int_oe,
    output logic                     ibi_req,
    output logic      [15:0]         ibi_cause,
    output logic                     emb_reset
);
    localparam int TS_MARGIN = TS_ALERT_MARGIN_NS / TS_LSB_NS;

    generate
        if (TS_WIDTH < 8 || TS_MARGIN < 1 ||
            $clog2(TS_MARGIN + 1) >= TS_WIDTH) begin : g_bad
            $error("serp_router: timestamp width or resolution unsupported");
        end
    endgenerate

    // ----------------------------------------
    // Routing registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            route_misc_select  <= ROUTE_RESET;
            route_event_select <= ROUTE_RESET;
        end else begin
            if (wr_misc) begin
                route_misc_select <= wr_data & MISC_WR_MASK;
            end
            if (wr_event) begin
                route_event_select <= wr_data & EVENT_WR_MASK;
            end
        end
    end

    // ----------------------------------------
    // Source gating
    // ----------------------------------------
    logic                 basic_en;
    logic                 motion_ok;
    logic [NUM_BASIC-1:0] ev_g;
    logic [7:0]           emb_g;
    logic                 ts_alert;

    // Enable only sampled in power-down so a change never hits a live detector
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            basic_en <= 1'b0;
        end else if (!active_mode) begin
            basic_en <= basic_events_on;
        end
    end

    assign motion_ok = active_mode && !bio_only;
    assign ev_g      = basic_event & {NUM_BASIC{motion_ok && basic_en}};
    assign emb_g     = emb_request & {8{motion_ok && embedded_features_on}};
    assign ts_alert  = motion_ok && embedded_features_on &&
                       (ts_count >= ({TS_WIDTH{1'b1}} - TS_WIDTH'(TS_MARGIN)));

    // ----------------------------------------
    // Basic event latches
    // ----------------------------------------
    serp_latch_t          bstate [NUM_BASIC];
    logic [NUM_BASIC-1:0] latch_on;
    logic [NUM_BASIC-1:0] read_clear;
    logic [NUM_BASIC-1:0] basic_flag;
    logic [NUM_BASIC-1:0] routed;

    assign routed[SRC_ORIENT] = route_event_select[EV_ORIENT];
    assign routed[SRC_FF]     = route_event_select[EV_FF];
    assign routed[SRC_WAKE]   = route_event_select[EV_WAKE];
    assign routed[SRC_TAP]    = route_event_select[EV_TAP];
    assign routed[SRC_SLEEP]  = route_event_select[EV_SLEEP];

    always_comb begin
        for (int i = 0; i < NUM_BASIC; i++) begin
            latch_on[i]   = latch_basic_events && routed[i];
            read_clear[i] = (rd_combined && !keep_flags_on_combined_read)
                            || rd_specific[i];
            basic_flag[i] = latch_on[i] ? (bstate[i] != SERP_IDLE) : ev_g[i];
        end
    end

    // Held until read, then released on the next output-data cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_BASIC; i++) begin
                bstate[i] <= SERP_IDLE;
            end
        end else begin
            for (int i = 0; i < NUM_BASIC; i++) begin
                if (!latch_on[i]) begin
                    bstate[i] <= SERP_IDLE;
                end else begin
                    case (bstate[i])
                        SERP_IDLE: begin
                            if (ev_g[i]) begin
                                bstate[i] <= SERP_HELD;
                            end
                        end
                        SERP_HELD: begin
                            if (read_clear[i]) begin
                                bstate[i] <= SERP_RELEASE;
                            end
                        end
                        SERP_RELEASE: begin
                            if (odr_tick) begin
                                bstate[i] <= ev_g[i] ? SERP_HELD : SERP_IDLE;
                            end
                        end
                        default: bstate[i] <= SERP_IDLE;
                    endcase
                end
            end
        end
    end

    // Reading latched sources also restarts the embedded engines unless keep_flags_on_combined_read is set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            emb_reset <= 1'b0;
        end else begin
            emb_reset <= latch_basic_events && !keep_flags_on_combined_read &&
                         (rd_combined || (|rd_specific));
        end
    end

    // ----------------------------------------
    // Embedded function flags
    // ----------------------------------------
    logic emb_int;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            emb_status <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!latch_embedded_events) begin
                    emb_status[i] <= emb_g[i];
                end else if (emb_g[i]) begin
                    emb_status[i] <= 1'b1;
                end else if (rd_emb_status && !embedded_ack_mask[i]) begin
                    emb_status[i] <= 1'b0;
                end
            end
        end
    end

    assign emb_int = |emb_status;

    // ----------------------------------------
    // Data-ready
    // ----------------------------------------
    logic lead_done;
    logic pulse_busy;
    logic sample_ready_flag_flag;
    logic sample_ready_flag_pin;

    // Output data lands a fixed time after the embedded engines fire
    serp_pulse_timer #(.CYCLES(EMB_LEAD_LEN)) u_lead (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (odr_tick && active_mode),
        .busy    (),
        .done    (lead_done)
    );

    serp_pulse_timer #(.CYCLES(SAMPLE_READY_FLAG_PULSE_LEN)) u_pulse (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (lead_done),
        .busy    (pulse_busy),
        .done    ()
    );

    // New sample wins over a read in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sample_ready_flag_flag <= 1'b0;
        end else if (lead_done) begin
            sample_ready_flag_flag <= 1'b1;
        end else if (rd_axis_high) begin
            sample_ready_flag_flag <= 1'b0;
        end
    end

    assign sample_ready_flag_pin = ready_pulse_mode ? pulse_busy : sample_ready_flag_flag;

    // ----------------------------------------
    // Readable source registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            combined_event_source <= 8'h00;
            status_reg            <= 8'h00;
        end else begin
            combined_event_source <= {3'b000, basic_flag};
            status_reg              <= 8'h00;
            status_reg[STAT_SAMPLE_READY_FLAG]   <= sample_ready_flag_flag;
            status_reg[STAT_GLOBAL] <= |basic_flag;
        end
    end

    // ----------------------------------------
    // Pin and in-band interrupt
    // ----------------------------------------
    logic [7:0] misc_vec;
    logic [7:0] event_vec;
    logic       any_src;
    logic       pin_active;

    assign misc_vec  = {boot_status, queue_full, queue_level, queue_overrun,
                        sample_ready_flag_pin, 3'b000};
    assign event_vec = {basic_flag[SRC_SLEEP], 1'b0, basic_flag[SRC_WAKE],
                        basic_flag[SRC_FF], basic_flag[SRC_TAP],
                        basic_flag[SRC_ORIENT], ts_alert, emb_int};
    assign any_src   = (|(route_misc_select & misc_vec)) ||
                       (|(route_event_select & event_vec));

    // Registered so the pin never shows decode glitches of the OR tree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_active <= 1'b0;
            int_out    <= 1'b0;
            int_oe     <= 1'b0;
        end else begin
            pin_active <= any_src;
            int_out    <= any_src ^ pin_polarity_low;
            int_oe     <= request_pin_enable &&
                          (!drain_select || any_src);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ibi_req   <= 1'b0;
            ibi_cause <= 16'h0000;
        end else begin
            ibi_req <= !request_pin_enable && any_src && !pin_active;
            if (any_src && !pin_active) begin
                ibi_cause <= {route_event_select & event_vec,
                              route_misc_select & misc_vec};
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_held_wake;
        latch_on[SRC_WAKE] && bstate[SRC_WAKE] == SERP_HELD && !read_clear[SRC_WAKE];
    endsequence

    sequence s_release_wake;
        latch_on[SRC_WAKE] && bstate[SRC_WAKE] == SERP_RELEASE && odr_tick && !ev_g[SRC_WAKE];
    endsequence

    a_powerdown_quiet: assert property (
        !active_mode |-> (ev_g == '0) && (emb_g == 8'h00) && !ts_alert)
        else $error("event passed while in power-down");

    a_bio_only_quiet: assert property (
        bio_only |-> (ev_g == '0) && (emb_g == 8'h00))
        else $error("event passed in biopotential-only state");

    a_pin_polarity: assert property (
        1'b1 |=> int_out == ($past(any_src) ^ $past(pin_polarity_low)))
        else $error("pin level disagrees with polarity and sources");

    a_drain_float: assert property (
        drain_select && !any_src |=> !int_oe)
        else $error("open drain drove inactive level");

    a_route_zero_bits: assert property (
        route_misc_select[2:0] == 3'b000 && !route_event_select[6])
        else $error("reserved routing bit set");

    a_or_combine: assert property (
        (route_event_select[EV_EMB] && emb_int) |=> pin_active)
        else $error("routed embedded source missing from pin");

    a_latch_hold: assert property (
        s_held_wake ##1 latch_on[SRC_WAKE] |-> basic_flag[SRC_WAKE])
        else $error("latched flag dropped before read");

    a_release_tick: assert property (
        s_release_wake |=> !latch_on[SRC_WAKE] || bstate[SRC_WAKE] == SERP_IDLE)
        else $error("latched flag not released on output-data cycle");

    a_unrouted_level: assert property (
        !routed[SRC_WAKE] |-> basic_flag[SRC_WAKE] == ev_g[SRC_WAKE])
        else $error("unrouted function was latched");

    a_keep_on_read: assert property (
        keep_flags_on_combined_read && rd_combined && !rd_specific[SRC_TAP]
        |-> !read_clear[SRC_TAP])
        else $error("combined read cleared flag despite keep bit");

    a_mask_keeps: assert property (
        latch_embedded_events && emb_status[0] && embedded_ack_mask[0] && rd_emb_status
        ##1 latch_embedded_events |-> emb_status[0])
        else $error("masked embedded flag cleared on read");

    a_sample_ready_flag_pulse: assert property (
        $rose(pulse_busy) |-> pulse_busy [*8])
        else $error("data-ready pulse too short");

    a_sample_ready_flag_clear: assert property (
        rd_axis_high && !lead_done |=> !sample_ready_flag_flag ##1 !status_reg[STAT_SAMPLE_READY_FLAG] || lead_done)
        else $error("axis high read did not clear data-ready");

endmodule

// file: testbench/sensor_event_pin_router_test.sv
// Self-checking bench for the sensor event pin router, one task per case.
// Assumes the host model owns writes, enables and all reads but rd_specific; bench drives the rest.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module sensor_event_pin_router_test import serp_pkg::*;;
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic ref_clk = 1'b0, resetn = 1'b0, odr_tick = 1'b0, active_mode = 1'b0;
    logic pin_polarity_low = 1'b0, drain_select = 1'b0, bio_only = 1'b0;
    logic latch_basic_events = 1'b0, latch_embedded_events = 1'b0;
    logic keep_flags_on_combined_read = 1'b0, ready_pulse_mode = 1'b0;
    logic boot_status = 1'b0, queue_full = 1'b0, queue_level = 1'b0;
    logic queue_overrun = 1'b0;
    logic [NUM_BASIC-1:0] basic_event = '0, rd_specific = '0;
    logic [7:0] emb_request = 8'h00, embedded_ack_mask = 8'h00, wr_data;
    logic [31:0] ts_count = 32'h0000_0000;
    logic wr_misc, wr_event, rd_combined, rd_emb_status, rd_axis_high;
    logic basic_events_on, embedded_features_on, request_pin_enable;
    logic [7:0] route_misc_select, route_event_select, combined_event_source;
    logic [7:0] status_reg, emb_status;
    logic int_out, int_oe, ibi_req, emb_reset;
    logic [15:0] ibi_cause;
    int errors = 0, checks_done = 0;
    always #10 ref_clk = ~ref_clk;
    serp_host_model host_inst (.ref_clk, .wr_misc, .wr_event, .wr_data, .rd_combined,
        .rd_emb_status, .rd_axis_high, .basic_events_on, .embedded_features_on,
        .request_pin_enable);
    serp_router #(.SAMPLE_READY_FLAG_PULSE_LEN(10), .EMB_LEAD_LEN(20)) serp_router_inst (.ref_clk,
        .resetn, .wr_misc, .wr_event, .wr_data, .route_misc_select, .route_event_select,
        .pin_polarity_low, .drain_select, .request_pin_enable, .latch_basic_events,
        .latch_embedded_events, .keep_flags_on_combined_read, .ready_pulse_mode,
        .basic_events_on, .embedded_features_on, .embedded_ack_mask, .active_mode,
        .bio_only, .odr_tick, .basic_event, .emb_request, .ts_count, .boot_status,
        .queue_full, .queue_level, .queue_overrun, .rd_combined, .rd_specific,
        .rd_emb_status, .rd_axis_high, .combined_event_source, .status_reg, .emb_status,
        .int_out, .int_oe, .ibi_req, .ibi_cause, .emb_reset);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic tick();
        odr_tick = 1'b1;
        cyc(1);
        odr_tick = 1'b0;
    endtask
    // One-cycle detector pulse; flags that are not held drop with it
    task automatic pulse(input int i);
        basic_event[i] = 1'b1;
        cyc(1);
        basic_event[i] = 1'b0;
        cyc(3);
    endtask
    task automatic wait_ready();
        int n;
        for (n = 0; n < 60 && status_reg[STAT_SAMPLE_READY_FLAG] !== 1'b1; n++) cyc(1);
        if (n == 60) begin
            errors++;
            $display("unexpected at %0t: data-ready never came", $time);
            final_report();
        end
        cyc(1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        `CHK(route_misc_select, 8'h00)
        `CHK(route_event_select, 8'h00)
        host_inst.write_reg(1'b0, 8'hFF);
        host_inst.write_reg(1'b1, 8'hFF);
        `CHK(route_misc_select, 8'hF8)
        `CHK(route_event_select, 8'hBF)
        host_inst.write_reg(1'b0, 8'h00);
        host_inst.write_reg(1'b1, 8'h08);
        $display("test regs done");
    endtask
    // Tap is routed, free-fall is not; each polarity and drive mix
    task automatic t_pin();
        for (int i = 0; i < 4; i++) begin
            {drain_select, pin_polarity_low} = 2'(i);
            basic_event[SRC_FF] = 1'b1;
            cyc(3);
            `CHK(int_out, pin_polarity_low)
            basic_event[SRC_TAP] = 1'b1;
            cyc(3);
            `CHK(int_out, !pin_polarity_low)
            `CHK(int_oe, 1'b1)
            basic_event = '0;
            cyc(3);
            `CHK(int_out, pin_polarity_low)
            `CHK(int_oe, !drain_select)
        end
        {drain_select, pin_polarity_low} = 2'b00;
        $display("test pin done");
    endtask
    task automatic t_latch();
        logic seen;
        latch_basic_events = 1'b1;
        pulse(SRC_WAKE);
        `CHK(combined_event_source, 8'h00)
        host_inst.write_reg(1'b1, 8'h20);
        pulse(SRC_WAKE);
        `CHK(combined_event_source, 8'h04)
        `CHK(status_reg[STAT_GLOBAL], 1'b1)
        `CHK(int_out, 1'b1)
        host_inst.read_src(0);
        seen = 1'b0;
        repeat (3) begin
            seen |= emb_reset;
            cyc(1);
        end
        `CHK(seen, 1'b1)
        `CHK(int_out, 1'b1)
        tick();
        cyc(3);
        `CHK(int_out, 1'b0)
        keep_flags_on_combined_read = 1'b1;
        pulse(SRC_WAKE);
        host_inst.read_src(0);
        `CHK(emb_reset, 1'b0)
        tick();
        cyc(3);
        `CHK(int_out, 1'b1)
        rd_specific[SRC_WAKE] = 1'b1;
        cyc(1);
        rd_specific = '0;
        tick();
        cyc(3);
        `CHK(int_out, 1'b0)
        keep_flags_on_combined_read = 1'b0;
        latch_basic_events = 1'b0;
        $display("test latch done");
    endtask
    task automatic t_power();
        active_mode = 1'b0;
        basic_event[SRC_WAKE] = 1'b1;
        cyc(3);
        `CHK(int_out, 1'b0)
        active_mode = 1'b1;
        bio_only = 1'b1;
        emb_request = 8'h01;
        cyc(3);
        `CHK(int_out, 1'b0)
        `CHK(emb_status, 8'h00)
        {bio_only, emb_request, basic_event} = '0;
        cyc(2);
        $display("test power done");
    endtask
    // Each queue or boot source alone, under its own routing bit only
    task automatic t_misc();
        for (int i = 0; i < 4; i++) begin
            host_inst.write_reg(1'b0, 8'h80 >> i);
            {boot_status, queue_full, queue_level, queue_overrun} = 4'h8 >> i;
            cyc(3);
            `CHK(int_out, 1'b1)
            {boot_status, queue_full, queue_level, queue_overrun} = ~(4'h8 >> i);
            cyc(3);
            `CHK(int_out, 1'b0)
        end
        {boot_status, queue_full, queue_level, queue_overrun} = 4'h0;
        host_inst.write_reg(1'b0, 8'h00);
        $display("test misc done");
    endtask
    task automatic t_ready();
        host_inst.write_reg(1'b0, 8'h08);
        host_inst.read_src(2);
        cyc(2);
        `CHK(status_reg[STAT_SAMPLE_READY_FLAG], 1'b0)
        latch_basic_events = 1'b1;
        tick();
        wait_ready();
        cyc(15);
        `CHK(int_out, 1'b1)
        host_inst.read_src(2);
        cyc(3);
        `CHK(int_out, 1'b0)
        ready_pulse_mode = 1'b1;
        tick();
        wait_ready();
        `CHK(int_out, 1'b1)
        cyc(12);
        `CHK(int_out, 1'b0)
        `CHK(status_reg[STAT_SAMPLE_READY_FLAG], 1'b1)
        {ready_pulse_mode, latch_basic_events} = 2'b00;
        host_inst.write_reg(1'b0, 8'h00);
        $display("test ready done");
    endtask
    task automatic t_emb();
        latch_embedded_events = 1'b1;
        emb_request = 8'h03;
        cyc(1);
        emb_request = 8'h00;
        cyc(3);
        `CHK(emb_status, 8'h03)
        embedded_ack_mask = 8'h01;
        host_inst.read_src(1);
        cyc(2);
        `CHK(emb_status, 8'h01)
        host_inst.write_reg(1'b1, 8'h01);
        cyc(1);
        `CHK(int_out, 1'b1)
        embedded_ack_mask = 8'h00;
        host_inst.read_src(1);
        cyc(2);
        `CHK(int_out, 1'b0)
        host_inst.write_reg(1'b1, 8'h02);
        ts_count = 32'hFFFF_FF9A;
        cyc(3);
        `CHK(int_out, 1'b0)
        ts_count = 32'hFFFF_FF9B;
        cyc(3);
        `CHK(int_out, 1'b1)
        ts_count = 32'h0000_0000;
        host_inst.write_reg(1'b1, 8'h20);
        cyc(2);
        $display("test embedded done");
    endtask
    task automatic t_ibi();
        logic [15:0] cause;
        cause = 16'h0000;
        host_inst.use_pin(1'b0);
        basic_event[SRC_WAKE] = 1'b1;
        repeat (6) begin
            if (ibi_req === 1'b1) cause = ibi_cause;
            cyc(1);
        end
        `CHK(cause, 16'h2000)
        basic_event = '0;
        $display("test in-band done");
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cyc(1);
        host_inst.set_basic(1'b1);
        cyc(5);
        resetn = 1'b1;
        cyc(1);
        t_regs();
        active_mode = 1'b1;
        t_pin();
        t_latch();
        t_power();
        t_misc();
        t_ready();
        t_emb();
        t_ibi();
        final_report();
    end
endmodule

// file: testbench/serp_host_model.sv
// Host model: routing writes, source reads and the host-owned enables.
// Assumes tasks are called right after a falling edge of ref_clk.
`timescale 1ns/1ps
module serp_host_model (
    input  wire logic ref_clk,
    output logic      wr_misc,
    output logic      wr_event,
    output logic [7:0] wr_data,
    output logic      rd_combined,
    output logic      rd_emb_status,
    output logic      rd_axis_high,
    output logic      basic_events_on,
    output logic      embedded_features_on,
    output logic      request_pin_enable
);
    // ----------------------------------------
    // Idle levels and bus cycles
    // ----------------------------------------
    initial begin
        {wr_misc, wr_event, rd_combined, rd_emb_status, rd_axis_high} = 5'h0;
        wr_data = 8'hA5;
        embedded_features_on = 1'b1;
        basic_events_on = 1'b0;
        request_pin_enable = 1'b1;
    end
    // Caller keeps the device in power-down around this call
    task automatic set_basic(input logic v);
        basic_events_on = v;
    endtask
    task automatic use_pin(input logic v);
        request_pin_enable = v;
    endtask
    // Strobe spans one rising edge; data is scrambled once released
    task automatic write_reg(input logic ev, input logic [7:0] d);
        wr_data = d;
        wr_misc = !ev;
        wr_event = ev;
        @(negedge ref_clk);
        wr_misc = 1'b0;
        wr_event = 1'b0;
        wr_data = ~d;
    endtask
    // k: 0 combined source, 1 embedded status, 2 axis high byte
    task automatic read_src(input int k);
        rd_combined = (k == 0);
        rd_emb_status = (k == 1);
        rd_axis_high = (k == 2);
        @(negedge ref_clk);
        {rd_combined, rd_emb_status, rd_axis_high} = 3'h0;
    endtask
endmodule
